// ===== core/cam_compare.sv
/*
  Masked identifier compare for one message object.
  Assumes inputs are already aligned to identifier bit order.
*/
`timescale 1ns/10ps
module cam_compare
  import cam_pkg::*;
(
  // carrier
  cam_cmp_if.cmp cmp
);
  logic [30:0] bitOk;
  logic [30:0] maskVec;
  logic [30:0] tagVec;
  logic [30:0] rxVec;
  logic [30:0] usedVec;

  assign maskVec = cmp.maskBits;
  assign tagVec  = cmp.tagBits;
  assign rxVec   = cmp.rxBits;
  // standard layout uses only id[10:0] plus rtr and ide
  assign usedVec = cmp.isExt ? 31'h7fffffff : 31'h00001fff;

  genvar i;
  generate
    for (i = 0; i < 31; i++) begin : g_bit
      assign bitOk[i] = ~usedVec[i] | ~maskVec[i] | (rxVec[i] == tagVec[i]);
    end
  endgenerate

  assign cmp.hit = &bitOk;
endmodule // cam_compare

// ===== core/cam_mask_regs.sv
/*
  Identifier mask registers of one CAN message object, with the matching
  tag inputs and the acceptance decision for received frames.
  Assumes the register port is an 8-bit SFR port in the core clock domain
  and the receive engine presents one frame identifier per valid pulse.
*/
// Behaviour
// - A mask bit at zero makes its identifier bit match regardless of value.
// - A mask bit at one requires the received bit to equal the tag bit.
// - The mask acts only on received frames and is ignored for transmission.
// - Standard layout: first mask register bits 7..0 mask identifier bits 10..3.
// - Standard layout: second register bits 7..5 mask id 2..0, bits 4..0 reserved.
// - Standard layout: third mask register is entirely reserved.
// - Fourth mask register bit 2 masks the remote-request flag.
// - Fourth register bit 0 masks the extension flag; bits 7..3 and 1 reserved in std.
// - Extended layout: first mask register bits 7..0 mask identifier bits 28..21.
// - Extended layout: second mask register bits 7..0 mask identifier bits 20..13.
// - Reserved bits read indeterminate and software must not write ones to them.
// - Masks have no reset value; software programs them before reception.
// - Extended layout: third mask register bits 7..0 mask identifier bits 12..5.
// - Extended layout: fourth register bits 7..3 mask id 4..0, rtr at 2, ide at 0.
// - Tag registers hold the reference bits, remote-request tag at bit 2 of the fourth.
`timescale 1ns/10ps
`include "cam_regs.svh"
module cam_mask_regs
  import cam_pkg::*;
#(
  parameter int REG_COUNT = 4
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // sfr port
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrite,
  input  wire logic        sfrRead,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  sfrRdata,
  // object configuration
  input  wire cam_layout_t layoutSel,
  input  wire logic        objRxEnable,
  input  wire logic [31:0] tagRegs,
  // receive engine
  input  wire logic        rxValid,
  input  wire logic        rxIsTransmit,
  input  wire logic [28:0] rxId,
  input  wire logic        rxRtr,
  input  wire logic        rxIde,
  // result
  output logic             rxAccept,
  output logic             rxReject,
  output logic      [31:0] maskOut
);
  // no reset: mask storage holds whatever software last wrote
  logic [7:0]           maskMem [REG_COUNT];

  // register port decode
  logic                 addrHit;
  logic                 rdHit;
  logic [1:0]           regIdx;
  logic [REG_COUNT-1:0] regSel;
  logic [REG_COUNT-1:0] regWrEn;
  logic [7:0]           rdKeep [REG_COUNT];
  logic [7:0]           rdByte [REG_COUNT];
  logic [7:0]           rdSel;
  logic [7:0]           rdata_next;

  // mask and tag words, byte 1 in the top bits
  logic [31:0]          maskWord;
  logic [31:0]          tagWord;

  // standard layout fields
  logic [7:0]           stdIdMaskUpperBits;
  logic [2:0]           stdIdMaskLowerBits;
  logic [7:0]           stdIdTagUpperBits;
  logic [2:0]           stdIdTagLowerBits;
  logic [28:0]          stdMaskId;
  logic [28:0]          stdTagId;

  // extended layout fields
  logic [7:0]           extIdMaskBitsTop;
  logic [7:0]           extIdMaskBitsMid;
  logic [7:0]           extIdMaskBitsLow;
  logic [4:0]           extIdMaskBitsTail;
  logic [28:0]          extMaskId;
  logic [28:0]          extTagId;

  // flag masks and tags
  logic                 remoteRequestMask;
  logic                 idExtensionMask;
  logic                 remoteRequestTag;
  logic                 idExtensionTag;

  // acceptance decision
  logic                 isExtLayout;
  logic                 hitWire;
  logic                 rxFrameSeen;
  logic                 accept_next;
  logic                 reject_next;

  cam_cmp_if cmpBus ();

  // layout is a level; a change mid-frame alters the compare at once
  assign isExtLayout = (layoutSel == CAM_LAYOUT_EXT);
  // unmapped addresses neither store nor read back
  assign addrHit     = (sfrAddr >= `CAM_MASK1_ADDR) && (sfrAddr <= `CAM_MASK4_ADDR);
  assign rdHit       = sfrRead && addrHit;
  // window is four aligned bytes, so the low bits pick the byte
  assign regIdx      = 2'(sfrAddr - `CAM_MASK1_ADDR);

  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_byte
      assign regSel[g]  = addrHit && (regIdx == 2'(g));
      assign regWrEn[g] = sfrWrite && regSel[g];
      // whole byte kept, reserved bits too
      always_ff @(posedge core_clk) begin
        if (regWrEn[g]) begin
          maskMem[g] <= sfrWdata;
        end
      end
      assign rdByte[g] = maskMem[g] & rdKeep[g];
    end
  endgenerate

  // reserved bits read back as zero
  // zero is one legal pick for indeterminate bits; software must not rely on it
  assign rdKeep[0]  = 8'hff;
  assign rdKeep[1]  = isExtLayout ? 8'hff : `CAM_STD_KEEP2;
  assign rdKeep[2]  = isExtLayout ? 8'hff : `CAM_STD_KEEP3;
  assign rdKeep[3]  = isExtLayout ? `CAM_EXT_KEEP4 : `CAM_STD_KEEP4;
  assign rdSel      = rdByte[regIdx];
  assign rdata_next = rdHit ? rdSel : `CAM_RSVD_READ;

  assign maskWord = {maskMem[0], maskMem[1], maskMem[2], maskMem[3]};
  assign tagWord  = tagRegs;

  // standard layout: id 10..3, then id 2..0
  assign stdIdMaskUpperBits = maskWord[31:24];
  assign stdIdMaskLowerBits = maskWord[16+`CAM_STD_LO_MSB:16+`CAM_STD_LO_LSB];
  assign stdIdTagUpperBits  = tagWord[31:24];
  assign stdIdTagLowerBits  = tagWord[16+`CAM_STD_LO_MSB:16+`CAM_STD_LO_LSB];
  // identifier bits above 10 never take part in a standard compare
  assign stdMaskId = {18'h00000, stdIdMaskUpperBits, stdIdMaskLowerBits};
  assign stdTagId  = {18'h00000, stdIdTagUpperBits, stdIdTagLowerBits};

  // extended layout spans all four bytes
  assign extIdMaskBitsTop  = maskWord[31:24];
  assign extIdMaskBitsMid  = maskWord[23:16];
  assign extIdMaskBitsLow  = maskWord[15:8];
  assign extIdMaskBitsTail = maskWord[7:`CAM_EXT_LO_LSB];
  assign extMaskId = {extIdMaskBitsTop, extIdMaskBitsMid, extIdMaskBitsLow, extIdMaskBitsTail};
  assign extTagId  = tagWord[31:`CAM_EXT_LO_LSB];

  assign remoteRequestMask = maskWord[`CAM_RTR_BIT];
  assign idExtensionMask   = maskWord[`CAM_IDE_BIT];
  // reference bits come from the tag registers
  assign remoteRequestTag  = tagWord[`CAM_RTR_BIT];
  assign idExtensionTag    = tagWord[`CAM_IDE_BIT];

  // reserved positions never reach the compare
  assign cmpBus.maskBits.id  = isExtLayout ? extMaskId : stdMaskId;
  assign cmpBus.tagBits.id   = isExtLayout ? extTagId : stdTagId;
  assign cmpBus.maskBits.rtr = remoteRequestMask;
  assign cmpBus.tagBits.rtr  = remoteRequestTag;
  assign cmpBus.maskBits.ide = idExtensionMask;
  assign cmpBus.tagBits.ide  = idExtensionTag;
  assign cmpBus.rxBits.id    = rxId;
  assign cmpBus.rxBits.rtr   = rxRtr;
  assign cmpBus.rxBits.ide   = rxIde;
  assign cmpBus.isExt        = isExtLayout;
  assign hitWire             = cmpBus.hit;

  cam_compare u_compare (
    .cmp (cmpBus)
  );

  // transmit frames never consult the mask
  assign rxFrameSeen = rxValid && !rxIsTransmit && objRxEnable;
  // exactly one of the two per received frame while objRxEnable is set, neither when it is clear
  assign accept_next = rxFrameSeen && hitWire;
  assign reject_next = rxFrameSeen && !hitWire;

  // zero outside a read, so a stale byte never lingers on the port
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= rdata_next;
    end
  end

  // single-cycle accept pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxAccept <= 1'b0;
    end else begin
      rxAccept <= accept_next;
    end
  end

  // single-cycle reject pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxReject <= 1'b0;
    end else begin
      rxReject <= reject_next;
    end
  end

  // cost: the compare sees a write one edge before this copy does
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      maskOut <= 32'h00000000;
    end else begin
      maskOut <= maskWord;
    end
  end
endmodule // cam_mask_regs

// ===== shared/cam_cmp_if.sv
/*
  Carrier between the mask register file and the compare unit.
  Assumes one clock domain; purely combinational signals.
*/
`timescale 1ns/10ps
interface cam_cmp_if;
  import cam_pkg::*;
  cam_frame_t maskBits;
  cam_frame_t tagBits;
  cam_frame_t rxBits;
  logic       isExt;
  logic       hit;
  modport regs (output maskBits, output tagBits, output rxBits, output isExt, input hit);
  modport cmp  (input maskBits, input tagBits, input rxBits, input isExt, output hit);
endinterface

// ===== shared/cam_pkg.sv
/*
  Types for the CAN acceptance mask block.
  Assumes cam_regs.svh is on the include path.
*/
package cam_pkg;
  typedef enum logic {
    CAM_LAYOUT_STD = 1'b0,
    CAM_LAYOUT_EXT = 1'b1
  } cam_layout_t;

  typedef struct packed {
    logic [28:0] id;
    logic        rtr;
    logic        ide;
  } cam_frame_t;
endpackage

// ===== shared/cam_regs.svh
/*
  Register addresses, field positions and read-back masks for the CAN
  acceptance mask block. Assumes an 8-bit special-function-register port.
*/
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH

`define CAM_MASK1_ADDR   8'hc4
`define CAM_MASK2_ADDR   8'hc5
`define CAM_MASK3_ADDR   8'hc6
`define CAM_MASK4_ADDR   8'hc7
`define CAM_RTR_BIT      2
`define CAM_IDE_BIT      0
`define CAM_STD_LO_MSB   7
`define CAM_STD_LO_LSB   5
`define CAM_EXT_LO_LSB   3
`define CAM_STD_ID_W     11
`define CAM_EXT_ID_W     29
`define CAM_RSVD_READ    8'h00
`define CAM_STD_KEEP2    8'he0
`define CAM_STD_KEEP3    8'h00
`define CAM_STD_KEEP4    8'h05
`define CAM_EXT_KEEP4    8'hfd

`endif

// ===== verif/cam_mask_regs_sva.sv
/* Checker on the cam_mask_regs ports; assumes one core_clk domain. */
`timescale 1ns/10ps
module cam_mask_regs_sva
  import cam_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // sfr port
  input wire logic [7:0]  sfrAddr,
  input wire logic        sfrWrite,
  input wire logic        sfrRead,
  input wire logic [7:0]  sfrWdata,
  input wire logic [7:0]  sfrRdata,
  // receive
  input wire cam_layout_t layoutSel,
  input wire logic        objRxEnable,
  input wire logic        rxValid,
  input wire logic        rxIsTransmit,
  input wire logic        rxAccept,
  input wire logic        rxReject,
  input wire logic [31:0] maskOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire take  = rxValid && !rxIsTransmit && objRxEnable;
  wire isStd = layoutSel == CAM_LAYOUT_STD;
  wire rd7   = sfrRead && sfrAddr == 8'hc7;
  property p_dec; take |=> rxAccept != rxReject; endproperty
  a_dec: assert property (p_dec) else $error("decision count");
  property p_none; !take |=> !rxAccept && !rxReject; endproperty
  a_none: assert property (p_none) else $error("stray decision");
  property p_m2; sfrRead && sfrAddr == 8'hc5 && isStd |=> sfrRdata[4:0] == 5'h00; endproperty
  a_m2: assert property (p_m2) else $error("m2 reserved");
  property p_m3; sfrRead && sfrAddr == 8'hc6 && isStd |=> sfrRdata == 8'h00; endproperty
  a_m3: assert property (p_m3) else $error("m3 reserved");
  property p_m4s; rd7 && isStd |=> sfrRdata[7:3] == 5'h00 && !sfrRdata[1]; endproperty
  a_m4s: assert property (p_m4s) else $error("m4 reserved");
  property p_m4e; rd7 && !isStd |=> !sfrRdata[1]; endproperty
  a_m4e: assert property (p_m4e) else $error("m4 bit1");
  property p_unm;
    sfrRead && (sfrAddr < 8'hc4 || sfrAddr > 8'hc7) |=> sfrRdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_wr;
    sfrWrite && sfrAddr == 8'hc4 ##1 !(sfrWrite && sfrAddr == 8'hc4)
      |=> maskOut[31:24] == $past(sfrWdata, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("m1 store");
  c_acc: cover property (take ##1 rxAccept);
  c_rej: cover property (take ##1 rxReject);
  c_ext: cover property (rd7 && !isStd);
endmodule // cam_mask_regs_sva
bind cam_mask_regs cam_mask_regs_sva chk_u (.core_clk, .reset_n, .sfrAddr, .sfrWrite, .sfrRead,
  .sfrWdata, .sfrRdata, .layoutSel, .objRxEnable, .rxValid, .rxIsTransmit, .rxAccept,
  .rxReject, .maskOut);

// ===== verif/cam_rx_model.sv
/* Receive engine model; assumes send is called after a clock edge. */
`timescale 1ns/10ps
module cam_rx_model (
  // clock
  input wire logic    core_clk,
  // frame out
  output logic        rxValid = 1'b0,
  output logic        rxIsTransmit = 1'b0,
  output logic [28:0] rxId = 29'h0,
  output logic        rxRtr = 1'b0,
  output logic        rxIde = 1'b0
);
  task automatic send(input logic [28:0] id, input logic rtr, ide, tx);
    @(posedge core_clk);
    rxValid <= 1'b1;
    rxIsTransmit <= tx;
    rxId <= id;
    rxRtr <= rtr;
    rxIde <= ide;
    @(posedge core_clk);
    // inverted after release so stale values never pass
    rxValid <= 1'b0;
    rxId <= ~id;
    rxRtr <= ~rtr;
    rxIde <= ~ide;
  endtask
endmodule // cam_rx_model

// ===== verif/test_cam_mask_regs.sv
/* Bench for cam_mask_regs; assumes cam_rx_model on the receive side. */
`timescale 1ns/10ps
module test_cam_mask_regs
  import cam_pkg::*;
;
  logic        core_clk = 1'b0, reset_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
  logic        objRxEnable = 1'b0, rdLast = 1'b0, rxValid, rxIsTransmit, rxRtr, rxIde;
  logic        rxAccept, rxReject, decQ[$];
  logic [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, rdQ[$];
  logic [28:0] rxId;
  logic [31:0] tagRegs = 32'h0, maskOut, m, t, r, v, mkQ[$];
  cam_layout_t layoutSel = CAM_LAYOUT_STD;
  int          failures = 0, checks = 0, seed = 32'h87ee;
  always #2 core_clk = ~core_clk;
  cam_mask_regs dut_u (.core_clk, .reset_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata,
    .sfrRdata, .layoutSel, .objRxEnable, .tagRegs, .rxValid, .rxIsTransmit, .rxId, .rxRtr,
    .rxIde, .rxAccept, .rxReject, .maskOut);
  cam_rx_model prt_u (.core_clk, .rxValid, .rxIsTransmit, .rxId, .rxRtr, .rxIde);
  task automatic cmpRd(input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] sfrRdata exp %h got %h", e, s);
    end
  endtask
  task automatic cmpDec(input logic e, input logic [1:0] s);
    checks++;
    if (s !== {e, !e}) begin
      failures++;
      $display("[ERR] decision exp %b got %b", {e, !e}, s);
    end
  endtask
  task automatic cmpMask(input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] maskOut exp %h got %h", e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [7:0] mb(int b);
    return 8'({m, 8'h00} >> (32 - 8 * b));
  endfunction
  task automatic sfr(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    sfrWrite <= w;
    sfrRead <= !w;
    sfrAddr <= a;
    sfrWdata <= d;
    if (!w) rdQ.push_back(d);
    @(posedge core_clk);
    sfrWrite <= 1'b0;
    sfrRead <= 1'b0;
  endtask
  task automatic frame(input logic tx, en);
    objRxEnable <= en;
    if (en && !tx) decQ.push_back(((r ^ t) & m) == 32'h0);
    prt_u.send(layoutSel ? r[31:3] : {r[20:3], r[31:21]}, r[2], r[0], tx);
  endtask
  always @(negedge core_clk) begin
    if (rdLast) cmpRd(rdQ.pop_front(), sfrRdata);
    if (rdLast && mkQ.size() > 0) cmpMask(mkQ.pop_front(), maskOut);
    if (reset_n && (rxAccept | rxReject) !== 1'b0) begin
      cmpDec(decQ.pop_front(), {rxAccept, rxReject});
    end
    rdLast = sfrRead;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int l = 0; l < 2; l++) begin
      layoutSel <= cam_layout_t'(l);
      v = l ? 32'hfffffffd : 32'hffe00005;
      for (int k = 0; k < 8; k++) begin
        m = k == 0 ? 32'h0 : k == 1 ? v : $random(seed) & v;
        t = $random(seed);
        tagRegs <= t;
        for (int b = 0; b < 4; b++) sfr(1'b1, 8'(8'hc4 + b), mb(b));
        mkQ.push_back(m);
        for (int b = 0; b < 5; b++) sfr(1'b0, 8'(8'hc4 + b), mb(b));
        for (int f = 0; f < 4; f++) begin
          r = $random(seed);
          if (f == 1) r = (t & m) | (r & ~m);
          frame(f == 2, f != 3);
        end
      end
    end
    repeat (4) @(posedge core_clk);
    finish_test;
  end
  // some twenty times the expected run
  initial begin
    #40000;
    failures++;
    finish_test;
  end
endmodule // test_cam_mask_regs
